// file: verilog/fec_pkg.sv
// constants, states and the state record shared by the flash erase control
// assumes an 8-bit special-function register bus and a 25 MHz ref_clk
//==========================================================
// fec_pkg
package fec_pkg;
  // register offsets on the special-function bus
  localparam logic [7:0] ERASE_TRIGGER_OFS = 8'h94;
  localparam logic [7:0] MASS_WIPE_OFS     = 8'hB2;
  localparam logic [7:0] BANK_SELECT_OFS   = 8'hB6;
  localparam logic [7:0] PAGE_WIPE_OFS     = 8'hB7;

  // field positions
  localparam int MASS_WIPE_BIT  = 1;
  localparam int PAGE_FIELD_LO  = 2;
  localparam int PAGE_FIELD_HI  = 7;
  localparam int BANK_FIELD_HI  = 2;

  // trigger patterns
  localparam logic [7:0] PAGE_START_PAT = 8'h55;
  localparam logic [7:0] MASS_START_PAT = 8'hAA;
  localparam logic [7:0] CYCLE_END_PAT  = 8'h00;

  // values after reset
  localparam logic [2:0] BANK_RESET  = 3'h1;
  localparam logic [5:0] PAGE_RESET  = 6'h00;
  localparam logic       MASS_RESET  = 1'b0;

  // clock figures
  localparam int REF_CLK_HZ   = 25000000;
  localparam int SYNC_STAGES  = 3;

  typedef enum logic [1:0] {
    FEC_IDLE,
    FEC_PAGE,
    FEC_MASS
  } fec_state_t;

  typedef struct packed {
    fec_state_t  state;
    logic [2:0]  bank;
    logic [5:0]  page;
    logic        mass_en;
    logic [7:0]  rd_data;
    logic [17:0] flash_addr;
  } fec_regs_t;
endpackage : fec_pkg

// file: verilog/fec_sync.sv
// three-stage synchroniser for a level arriving from outside ref_clk
// assumes the input may change at any time; output settles once stages two and three agree
`timescale 1ns/1ps
//==========================================================
// fec_sync
module fec_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // level in and filtered level out
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic [fec_pkg::SYNC_STAGES-1:0] stage;
    logic                            level;
  } fec_sync_t;

  fec_sync_t sync_r;
  fec_sync_t sync_nxt;

  // shift chain; stage 0 feeds only stage 1 to keep metastability contained
  always_comb begin
    sync_nxt       = sync_r;
    sync_nxt.stage = {sync_r.stage[fec_pkg::SYNC_STAGES-2:0], async_in};
    if (sync_r.stage[1] == sync_r.stage[2]) begin
      sync_nxt.level = sync_r.stage[2];
    end
  end

  // registered state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r.level;
endmodule : fec_sync

// file: verilog/fec_erase_ctrl.sv
// flash erase control: trigger, mass-enable, page address and bank registers
// assumes a synchronous special-function bus from the MPU on ref_clk and a flash array that
// erases while its request level is high
//
// Functional notes
// - writing 0x55 to erase_trigger starts a page erase cycle
// - writing 0xAA starts mass erase only with enable bit set and debug port on
// - any other trigger value is ignored and never alters a running cycle
// - a cycle stays open until firmware writes 0x00 to erase_trigger
// - write-only mass enable defaults to 0 and is consumed by each mass cycle
// - page field and bank select together give the page to erase
`timescale 1ns/1ps
//==========================================================
// fec_erase_ctrl
module fec_erase_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // special-function register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic [7:0]       sfr_rdata,
  // debug port enable pin
  input  wire logic        debug_access_port,
  // mpu program address mapping
  input  wire logic [15:0] mpu_addr,
  output logic [17:0]      flash_addr,
  // flash array erase requests
  output logic             page_erase_req,
  output logic             mass_erase_req,
  output logic [8:0]       erase_page_addr,
  output logic             erase_busy
);
  fec_pkg::fec_regs_t regs_r;
  fec_pkg::fec_regs_t regs_nxt;
  logic               dbg_on;

  // the debug pin is asynchronous to ref_clk
  fec_sync u_dbg_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (debug_access_port),
    .sync_out (dbg_on)
  );

  // single-address write decode, used for every register
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction : wr_hit

  //==========================================================
  // next-state logic
  always_comb begin
    regs_nxt = regs_r;
    // bank select is the only readable register; others read as zero
    if (wr_hit(sfr_wr, sfr_addr, fec_pkg::BANK_SELECT_OFS)) begin
      regs_nxt.bank = sfr_wdata[fec_pkg::BANK_FIELD_HI:0];
    end
    if (wr_hit(sfr_wr, sfr_addr, fec_pkg::PAGE_WIPE_OFS)) begin
      regs_nxt.page = sfr_wdata[fec_pkg::PAGE_FIELD_HI:fec_pkg::PAGE_FIELD_LO];
    end
    if (wr_hit(sfr_wr, sfr_addr, fec_pkg::MASS_WIPE_OFS)) begin
      regs_nxt.mass_en = sfr_wdata[fec_pkg::MASS_WIPE_BIT];
    end
    // trigger sequencer; patterns other than the three named fall through untouched
    if (wr_hit(sfr_wr, sfr_addr, fec_pkg::ERASE_TRIGGER_OFS)) begin
      unique case (regs_r.state)
        fec_pkg::FEC_IDLE: begin
          if (sfr_wdata == fec_pkg::PAGE_START_PAT) begin
            regs_nxt.state = fec_pkg::FEC_PAGE;
          end else if (sfr_wdata == fec_pkg::MASS_START_PAT && regs_r.mass_en && dbg_on) begin
            regs_nxt.state   = fec_pkg::FEC_MASS;
            regs_nxt.mass_en = fec_pkg::MASS_RESET; // consumed, must be rewritten
          end
        end // any other value: no effect
        fec_pkg::FEC_PAGE,
        fec_pkg::FEC_MASS: begin
          if (sfr_wdata == fec_pkg::CYCLE_END_PAT) begin
            regs_nxt.state = fec_pkg::FEC_IDLE;
          end
        end // start patterns while open are ignored
        // the fourth code of the two-bit state is unused; fall back to idle rather than lock up
        default: begin
          regs_nxt.state = fec_pkg::FEC_IDLE;
        end
      endcase
    end
    // registered read data, valid the cycle after sfr_rd
    regs_nxt.rd_data = 8'h00;
    if (sfr_rd && sfr_addr == fec_pkg::BANK_SELECT_OFS) begin
      regs_nxt.rd_data = {5'h00, regs_r.bank};
    end
    // program address map: upper half goes through the selected bank
    if (mpu_addr[15]) begin
      regs_nxt.flash_addr = {regs_r.bank, mpu_addr[14:0]};
    end else begin
      regs_nxt.flash_addr = {3'h0, mpu_addr[14:0]};
    end
  end

  //==========================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regs_r.state      <= fec_pkg::FEC_IDLE;
      regs_r.bank       <= fec_pkg::BANK_RESET;
      regs_r.page       <= fec_pkg::PAGE_RESET;
      regs_r.mass_en    <= fec_pkg::MASS_RESET;
      regs_r.rd_data    <= 8'h00;
      regs_r.flash_addr <= 18'h00000;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  //==========================================================
  // outputs; the page address is the live field, so a write while a cycle is open moves it at once
  assign page_erase_req  = (regs_r.state == fec_pkg::FEC_PAGE);
  assign mass_erase_req  = (regs_r.state == fec_pkg::FEC_MASS);
  assign erase_page_addr = {regs_r.bank, regs_r.page};
  assign erase_busy      = (regs_r.state != fec_pkg::FEC_IDLE);
  assign sfr_rdata       = regs_r.rd_data;
  assign flash_addr      = regs_r.flash_addr;
endmodule : fec_erase_ctrl

// file: testbench/fec_flash_model.sv
// flash array stand-in: tallies erase cycles and the page last asked for
// assumes request levels from fec_erase_ctrl on ref_clk
`timescale 1ns/1ps
//==========
// fec_flash_model
module fec_flash_model (
  // requests from the control block
  input  wire logic       ref_clk, page_erase_req, mass_erase_req,
  input  wire logic [8:0] erase_page_addr,
  // tallies for the bench
  output int              page_hits, mass_hits,
  output logic [8:0]      last_page
);
  logic pq = 0, mq = 0;
  initial {page_hits, mass_hits, last_page} = '0;
  // count on the opening edge only; the array keeps erasing while the level stays up
  always @(posedge ref_clk) begin
    if (page_erase_req && !pq) begin
      page_hits++;
      last_page = erase_page_addr;
    end
    if (mass_erase_req && !mq) mass_hits++;
    pq = page_erase_req;
    mq = mass_erase_req;
  end
endmodule : fec_flash_model

// file: testbench/fec_erase_checker.sv
// port checker for the flash erase control
// assumes it is bound onto fec_erase_ctrl and sees only its ports
`timescale 1ns/1ps
//==========
// fec_erase_checker
module fec_erase_checker (
  input wire logic        ref_clk, reset, sfr_wr, page_erase_req, mass_erase_req, erase_busy,
  input wire logic [7:0]  sfr_addr, sfr_wdata,
  input wire logic [15:0] mpu_addr,
  input wire logic [17:0] flash_addr,
  input wire logic [8:0]  erase_page_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // any write to the trigger register
  wire trig = sfr_wr && sfr_addr == 8'h94;
  a_page_start: assert property (trig && sfr_wdata == 8'h55 && !erase_busy |=> page_erase_req)
    else $error("page cycle not opened");
  a_mass_cause: assert property ($rose(mass_erase_req) |-> $past(trig && sfr_wdata == 8'hAA))
    else $error("mass cycle without its pattern");
  a_other_ignored: assert property (trig && !(sfr_wdata inside {8'h55, 8'hAA, 8'h00})
    |=> $stable({page_erase_req, mass_erase_req})) else $error("stray pattern acted on");
  a_cycle_close: assert property (trig && sfr_wdata == 8'h00 |=> !erase_busy)
    else $error("cycle not closed");
  a_hold_open: assert property (erase_busy && !(trig && sfr_wdata == 8'h00) |=> erase_busy)
    else $error("cycle dropped early");
  a_bank_field: assert property (sfr_wr && sfr_addr == 8'hB6 |=> erase_page_addr[8:6] == $past(sfr_wdata[2:0]))
    else $error("bank field wrong");
  a_page_field: assert property (sfr_wr && sfr_addr == 8'hB7 |=> erase_page_addr[5:0] == $past(sfr_wdata[7:2]))
    else $error("page field wrong");
  a_bank_map: assert property (!sfr_wr |=> flash_addr ==
    {($past(mpu_addr[15]) ? erase_page_addr[8:6] : 3'h0), $past(mpu_addr[14:0])}) else $error("flash address wrong");
  c_page: cover property (page_erase_req && erase_page_addr[8:6] == 3'h3);
  c_mass: cover property ($rose(mass_erase_req));
  c_busy_trig: cover property (trig && erase_busy && sfr_wdata == 8'hAA);
endmodule : fec_erase_checker
bind fec_erase_ctrl fec_erase_checker u_chk (.*);

// file: testbench/testbench.sv
// self-checking bench for fec_erase_ctrl with a flash array stand-in
// assumes the port checker is bound from its own file
`timescale 1ns/1ps
//==========
// testbench
module testbench;
  logic        ref_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, debug_access_port = 0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [15:0] mpu_addr = 16'h0000;
  logic [17:0] flash_addr;
  logic [8:0]  erase_page_addr, last_page;
  logic        page_erase_req, mass_erase_req, erase_busy;
  int          bad_count = 0, total_checks = 0, page_hits, mass_hits;
  logic [7:0]  pat [3] = '{8'h33, 8'hAA, 8'h55};
  always #20 ref_clk = ~ref_clk;
  fec_erase_ctrl DUT (.ref_clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .debug_access_port,
    .mpu_addr, .flash_addr, .page_erase_req, .mass_erase_req, .erase_page_addr, .erase_busy);
  fec_flash_model flash (.ref_clk, .page_erase_req, .mass_erase_req, .erase_page_addr, .page_hits, .mass_hits, .last_page);
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; strobe held across the taking edge
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk) #1;
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
    @(posedge ref_clk) #1;
    {sfr_wr, sfr_rd} = 2'b00;
  endtask : bus
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset = 0;
    bus(8'hB6, 8'h00, 0); chk(sfr_rdata, 8'h01);
    bus(8'h94, 8'h00, 0); chk(sfr_rdata, 8'h00);
    bus(8'hB6, 8'h03, 1);
    bus(8'hB6, 8'h00, 0); chk(sfr_rdata, 8'h03);
    bus(8'hB7, 8'h14, 1);
    bus(8'h94, 8'h55, 1); chk({erase_busy, page_erase_req, erase_page_addr}, {2'b11, 9'h0C5});
    foreach (pat[i]) begin
      bus(8'h94, pat[i], 1); chk({mass_erase_req, page_erase_req}, 2'b01);
    end
    bus(8'h94, 8'h00, 1); chk({erase_busy, page_erase_req}, 2'b00);
    bus(8'h94, 8'h12, 1); chk(erase_busy, 1'b0);
    // debug port still off: mass pattern must be refused
    bus(8'hB2, 8'h02, 1);
    bus(8'h94, 8'hAA, 1); chk(mass_erase_req, 1'b0);
    debug_access_port = 1;
    repeat (5) @(posedge ref_clk);
    bus(8'hB2, 8'h02, 1);
    bus(8'h94, 8'hAA, 1); chk({erase_busy, mass_erase_req}, 2'b11);
    bus(8'h94, 8'h00, 1);
    bus(8'h94, 8'hAA, 1); chk(mass_erase_req, 1'b0);
    mpu_addr = 16'h8123;
    repeat (2) @(posedge ref_clk);
    #1 chk(flash_addr, 18'h18123);
    mpu_addr = 16'h0123;
    repeat (2) @(posedge ref_clk);
    #1 chk(flash_addr, 18'h00123);
    chk({page_hits[7:0], mass_hits[7:0], last_page}, {8'h01, 8'h01, 9'h0C5});
    give_verdict;
  end
endmodule : testbench
